// >>> common/mff_pkg.sv
package mff_pkg;
    localparam logic [7:0] OP_FAST = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
    localparam logic [7:0] OP_DUAL_IO = 8'hBB;
    localparam logic [7:0] OP_QUAD_IO = 8'hEB;
    localparam logic [7:0] OP_WRAP_SET = 8'h77;
    localparam logic [7:0] OP_MODE_RESET = 8'hFF;
    localparam logic [1:0] CONT_CODE = 2'h2;
    localparam int CONT_LSB = 4;
    localparam int WRAP_DIS_BIT = 4;
    localparam int WRAP_LEN_LSB = 5;
    localparam logic [4:0] CMD_CLOCKS = 5'h08;
    localparam logic [4:0] WRAP_CLOCKS = 5'h08;
    localparam logic [4:0] DUMMY_FAST = 5'h08;
    localparam logic [4:0] DUMMY_QUAD_IO = 5'h04;
    localparam logic [4:0] DUMMY_DUAL_IO = 5'h00;
    localparam logic [4:0] RESET_SHORT = 5'h08;
    localparam logic [4:0] RESET_LONG = 5'h10;
    localparam logic [7:0] MODE_RESET_VAL = 8'h00;
    localparam logic WRAP_DIS_RESET = 1'b1;
    localparam logic [1:0] WRAP_LEN_RESET = 2'h0;
    localparam logic [7:0] CMD_RESET = 8'h00;

    typedef enum logic [2:0]
    {
        FR_CMD = 3'b000,
        FR_ADDR = 3'b001,
        FR_MODE = 3'b011,
        FR_DUMMY = 3'b010,
        FR_DATA = 3'b110,
        FR_WRAP = 3'b111,
        FR_IGN = 3'b101
    } mff_state_t;
endpackage : mff_pkg

// >>> hdl/mff_read_front.sv
`timescale 1ns/1ps
`default_nettype none
module mff_read_front
    import mff_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // serial link pins
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic data_lane_zero_in,
    output logic data_lane_zero_out,
    output logic data_lane_zero_oe,
    input wire logic data_lane_one_in,
    output logic data_lane_one_out,
    output logic data_lane_one_oe,
    input wire logic data_lane_two_in,
    output logic data_lane_two_out,
    output logic data_lane_two_oe,
    input wire logic data_lane_three_in,
    output logic data_lane_three_out,
    output logic data_lane_three_oe,
    // status and configuration
    input wire logic quad_enable_bit,
    output logic [7:0] continuous_mode_bits,
    output logic wrap_disable_bit,
    output logic [1:0] wrap_length_field,
    // memory array read port
    output logic [23:0] mem_addr,
    input wire logic [7:0] mem_data
);
    function automatic logic [2:0] lane_width(mff_state_t st, logic [7:0] op);
        begin
            lane_width = 3'd1;
            if (st == FR_WRAP)
                lane_width = 3'd4;
            else if (st == FR_ADDR || st == FR_MODE)
            begin
                if (op == OP_DUAL_IO)
                    lane_width = 3'd2;
                else if (op == OP_QUAD_IO)
                    lane_width = 3'd4;
            end
            else if (st == FR_DATA)
            begin
                if (op == OP_DUAL_OUT || op == OP_DUAL_IO)
                    lane_width = 3'd2;
                else if (op == OP_QUAD_OUT || op == OP_QUAD_IO)
                    lane_width = 3'd4;
            end
        end
    endfunction : lane_width

    function automatic logic [31:0] shift_in(logic [31:0] sh, logic [3:0] l,
                                             logic [2:0] w);
        begin
            case (w)
                3'd2: shift_in = {sh[29:0], l[1:0]};
                3'd4: shift_in = {sh[27:0], l[3:0]};
                default: shift_in = {sh[30:0], l[0]};
            endcase
        end
    endfunction : shift_in

    function automatic logic [4:0] phase_clocks(logic [4:0] bits, logic [2:0] w);
        begin
            case (w)
                3'd2: phase_clocks = {1'b0, bits[4:1]};
                3'd4: phase_clocks = {2'b00, bits[4:2]};
                default: phase_clocks = bits;
            endcase
        end
    endfunction : phase_clocks

    function automatic logic [4:0] dummy_clocks(logic [7:0] op);
        begin
            case (op)
                OP_QUAD_IO: dummy_clocks = DUMMY_QUAD_IO;
                OP_DUAL_IO: dummy_clocks = DUMMY_DUAL_IO;
                default: dummy_clocks = DUMMY_FAST;
            endcase
        end
    endfunction : dummy_clocks

    function automatic logic [23:0] next_addr(logic [23:0] a, logic wrap,
                                              logic [1:0] len);
        logic [23:0] m;
        logic [23:0] inc;
        begin
            case (len)
                2'h0: m = 24'h000007;
                2'h1: m = 24'h00000F;
                2'h2: m = 24'h00001F;
                default: m = 24'h00003F;
            endcase
            inc = a + 24'h000001;
            next_addr = wrap ? ((a & ~m) | (inc & m)) : inc;
        end
    endfunction : next_addr

    // pins are asynchronous to clk: two flops before use
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic sclk_prev_q;
    logic cs_prev_q;
    always_ff @(posedge clk)
    begin
        sync1_q <= {spi_cs_n, spi_sclk, data_lane_three_in, data_lane_two_in,
                    data_lane_one_in, data_lane_zero_in};
        sync2_q <= sync1_q;
        sclk_prev_q <= sync2_q[4];
        cs_prev_q <= sync2_q[5];
    end

    logic cs_low;
    logic sc_rise;
    logic sc_fall;
    logic cs_fall;
    logic cs_rise;
    logic [3:0] lanes_s;
    assign cs_low = ~sync2_q[5];
    assign sc_rise = cs_low & sync2_q[4] & ~sclk_prev_q;
    assign sc_fall = cs_low & ~sync2_q[4] & sclk_prev_q;
    assign cs_fall = cs_prev_q & ~sync2_q[5];
    assign cs_rise = ~cs_prev_q & sync2_q[5];
    assign lanes_s = sync2_q[3:0];

    mff_state_t st_q, st_d;
    logic [4:0] cnt_q, cnt_d, fcnt_q, fcnt_d;
    logic [31:0] sh_q, sh_d;
    logic [7:0] cmd_q, cmd_d, ccmd_q, ccmd_d, mode_q, mode_d, out_q, out_d;
    logic [23:0] addr_q, addr_d;
    logic [2:0] bit_q, bit_d, w;
    logic cont_q, cont_d, ones_q, ones_d, wdis_q, wdis_d;
    logic [1:0] wlen_q, wlen_d;
    logic [3:0] drv_q, drv_d, oe_q, oe_d;
    logic wrap_on;

    assign w = lane_width(st_q, cmd_q);
    assign wrap_on = ~wdis_q & (cmd_q == OP_QUAD_IO);

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        fcnt_d = fcnt_q;
        sh_d = sh_q;
        cmd_d = cmd_q;
        ccmd_d = ccmd_q;
        mode_d = mode_q;
        cont_d = cont_q;
        out_d = out_q;
        addr_d = addr_q;
        bit_d = bit_q;
        ones_d = ones_q;
        wdis_d = wdis_q;
        wlen_d = wlen_q;
        drv_d = drv_q;
        oe_d = oe_q;
        if (!cs_low)
        begin
            st_d = FR_CMD;
            cnt_d = 5'd0;
            fcnt_d = 5'd0;
            bit_d = 3'd0;
            ones_d = 1'b1;
            oe_d = 4'h0;
            // all-ones frame of 8 or 16 clocks ends continuous mode
            if (cs_rise && ones_q &&
                (fcnt_q == RESET_SHORT || fcnt_q == RESET_LONG))
            begin
                mode_d = MODE_RESET_VAL;
                cont_d = 1'b0;
            end
        end
        else if (cs_fall)
        begin
            // skipping the opcode means reusing the stored command
            st_d = cont_q ? FR_ADDR : FR_CMD;
            cmd_d = cont_q ? ccmd_q : cmd_q;
        end
        else if (sc_rise)
        begin
            sh_d = shift_in(sh_q, lanes_s, w);
            cnt_d = cnt_q + 5'd1;
            fcnt_d = (fcnt_q == 5'h1F) ? fcnt_q : fcnt_q + 5'd1;
            ones_d = ones_q & lanes_s[0];
            case (st_q)
                FR_CMD:
                    if (cnt_q == CMD_CLOCKS - 5'd1)
                    begin
                        cnt_d = 5'd0;
                        cmd_d = sh_d[7:0];
                        case (sh_d[7:0])
                            OP_FAST, OP_DUAL_OUT, OP_DUAL_IO: st_d = FR_ADDR;
                            OP_QUAD_OUT, OP_QUAD_IO:
                                st_d = quad_enable_bit ? FR_ADDR
                                                       : FR_IGN;
                            OP_WRAP_SET: st_d = FR_WRAP;
                            default: st_d = FR_IGN;
                        endcase
                        if (sh_d[7:0] == OP_MODE_RESET)
                        begin
                            mode_d = MODE_RESET_VAL;
                            cont_d = 1'b0;
                        end
                    end
                FR_ADDR:
                    if (cnt_q == phase_clocks(5'd24, w) - 5'd1)
                    begin
                        cnt_d = 5'd0;
                        addr_d = sh_d[23:0];
                        st_d = (cmd_q == OP_DUAL_IO || cmd_q == OP_QUAD_IO)
                               ? FR_MODE : FR_DUMMY;
                    end
                FR_MODE:
                    if (cnt_q == phase_clocks(5'd8, w) - 5'd1)
                    begin
                        cnt_d = 5'd0;
                        mode_d = sh_d[7:0];
                        cont_d = sh_d[CONT_LSB+:2] == CONT_CODE;
                        ccmd_d = cmd_q;
                        st_d = (dummy_clocks(cmd_q) == 5'd0) ? FR_DATA
                                                             : FR_DUMMY;
                    end
                FR_DUMMY:
                    if (cnt_q == dummy_clocks(cmd_q) - 5'd1)
                    begin
                        cnt_d = 5'd0;
                        st_d = FR_DATA;
                    end
                FR_WRAP:
                    if (cnt_q == WRAP_CLOCKS - 5'd1)
                    begin
                        wdis_d = sh_d[WRAP_DIS_BIT];
                        wlen_d = sh_d[WRAP_LEN_LSB+:2];
                        st_d = FR_IGN;
                    end
                default: ;
            endcase
        end
        else if (sc_fall && st_q == FR_DATA)
        begin
            // lanes turn round only on the first data falling edge
            oe_d = (w == 3'd4) ? 4'hF : (w == 3'd2) ? 4'h3 : 4'h2;
            if (bit_q == 3'd0)
            begin
                out_d = mem_data;
                addr_d = next_addr(addr_q, wrap_on, wlen_q);
            end
            else
                out_d = out_q << w;
            bit_d = bit_q + w;
            case (w)
                3'd4: drv_d = out_d[7:4];
                3'd2: drv_d = {2'b00, out_d[7:6]};
                default: drv_d = {2'b00, out_d[7], 1'b0};
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_q <= FR_CMD;
            cnt_q <= 5'd0;
            fcnt_q <= 5'd0;
            sh_q <= 32'h00000000;
            cmd_q <= CMD_RESET;
            ccmd_q <= CMD_RESET;
            mode_q <= MODE_RESET_VAL;
            cont_q <= 1'b0;
            out_q <= 8'h00;
            addr_q <= 24'h000000;
            bit_q <= 3'd0;
            ones_q <= 1'b1;
            wdis_q <= WRAP_DIS_RESET;
            wlen_q <= WRAP_LEN_RESET;
            drv_q <= 4'h0;
            oe_q <= 4'h0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            fcnt_q <= fcnt_d;
            sh_q <= sh_d;
            cmd_q <= cmd_d;
            ccmd_q <= ccmd_d;
            mode_q <= mode_d;
            cont_q <= cont_d;
            out_q <= out_d;
            addr_q <= addr_d;
            bit_q <= bit_d;
            ones_q <= ones_d;
            wdis_q <= wdis_d;
            wlen_q <= wlen_d;
            drv_q <= drv_d;
            oe_q <= oe_d;
        end
    end

    assign {data_lane_three_out, data_lane_two_out} = drv_q[3:2];
    assign {data_lane_one_out, data_lane_zero_out} = drv_q[1:0];
    assign {data_lane_three_oe, data_lane_two_oe} = oe_q[3:2];
    assign {data_lane_one_oe, data_lane_zero_oe} = oe_q[1:0];
    assign continuous_mode_bits = mode_q;
    assign wrap_disable_bit = wdis_q;
    assign wrap_length_field = wlen_q;
    assign mem_addr = addr_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_dummy_no_drive: assert property (st_q == FR_DUMMY |-> oe_q == 4'h0)
        else $error("lanes driven during dummy clocks");
    a_dual_out_lanes: assert property ((cmd_q == OP_DUAL_OUT && oe_q != 4'h0)
        |-> oe_q == 4'h3)
        else $error("dual output read not on two lanes");
    a_quad_out_lanes: assert property ((cmd_q == OP_QUAD_OUT && oe_q != 4'h0)
        |-> oe_q == 4'hF)
        else $error("quad output read not on four lanes");
    a_quad_gate_off: assert property ((st_q == FR_CMD && sc_rise &&
        cnt_q == 5'd7 && !quad_enable_bit &&
        (sh_d[7:0] == OP_QUAD_OUT || sh_d[7:0] == OP_QUAD_IO))
        |=> st_q == FR_IGN)
        else $error("quad read accepted without quad enable");
    a_cont_skip_op: assert property ((cs_fall && cont_q)
        |=> st_q == FR_ADDR && cmd_q == ccmd_q)
        else $error("continuous frame did not skip opcode");
    a_full_opcode: assert property ((cs_fall && !cont_q) |=> st_q == FR_CMD)
        else $error("normal frame did not expect opcode");
    a_mode_capture: assert property ((st_q == FR_MODE && st_d != FR_MODE &&
        !cs_fall && cs_low)
        |=> cont_q == (mode_q[5:4] == CONT_CODE))
        else $error("continuation code not taken from mode bits");
    a_wrap_bound: assert property ((sc_fall && st_q == FR_DATA &&
        bit_q == 3'd0 && wrap_on)
        |=> addr_q[23:6] == $past(addr_q[23:6]))
        else $error("wrapping read left its section");
    a_linear_step: assert property ((sc_fall && st_q == FR_DATA &&
        bit_q == 3'd0 && !wrap_on)
        |=> addr_q == $past(addr_q) + 24'h000001)
        else $error("address did not step by one");
    a_powerup_state: assert property ($past(reset)
        |-> !cont_q && wdis_q && mode_q == 8'h00)
        else $error("bad state after reset");

    c_quad_io_data: cover property (st_q == FR_DATA && cmd_q == OP_QUAD_IO
        && oe_q == 4'hF);
    c_cont_frame: cover property (cs_fall && cont_q);
    c_wrap_set: cover property (st_q == FR_WRAP ##1 st_q == FR_IGN);
    c_mode_reset: cover property (cont_q ##1 !cont_q);
endmodule : mff_read_front
`default_nettype wire

// >>> testbench/mff_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mff_host_model
(
    // system clock, used only for pacing
    input wire logic clk,
    // link pins driven by the host
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic [3:0] h_out,
    output logic [3:0] h_oe,
    // resolved lanes and device enables
    input wire logic [3:0] lane,
    input wire logic [3:0] dev_oe
);
    logic [7:0] got[$];
    logic [3:0] oe_seen;
    int oe_bad;

    initial
    begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        h_out = 4'h0;
        h_oe = 4'h0;
    end

    // one link clock, 200 ns; lanes change with the falling edge
    task tick(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] s);
        h_out = v;
        h_oe = oe;
        repeat (4) @(negedge clk);
        spi_sclk = 1'b1;
        repeat (2) @(negedge clk);
        s = lane;
        repeat (2) @(negedge clk);
        spi_sclk = 1'b0;
    endtask : tick

    // msb first, higher lane carries the higher bit
    task send(input logic [23:0] v, input int nb, input int w);
        logic [3:0] s;
        for (int k = nb - w; k >= 0; k -= w)
            tick(4'(v >> k) & 4'((1 << w) - 1), 4'((1 << w) - 1), s);
    endtask : send

    // opcode, address, mode bits, dummy, then data
    task run(input logic skip, input logic [7:0] op, input int aw,
             input logic [23:0] a, input int mw, input logic [7:0] m,
             input int dm, input int dw, input int n);
        logic [3:0] s;
        logic [7:0] b;
        got.delete();
        oe_seen = 4'h0;
        oe_bad = 0;
        b = 8'h00;
        spi_cs_n = 1'b0;
        repeat (4) @(negedge clk);
        if (!skip)
            send({16'h0000, op}, 8, 1);
        if (aw > 0)
            send(a, 24, aw);
        if (mw > 0)
            send({16'h0000, m}, 8, mw);
        // lanes released; sampled values are thrown away
        for (int i = 0; i < dm; i++)
        begin
            tick(4'h0, 4'h0, s);
            if (dev_oe != 4'h0)
                oe_bad++;
        end
        for (int i = 0; i < n; i++)
        begin
            for (int j = 0; j < 8 / dw; j++)
            begin
                tick(4'h0, 4'h0, s);
                oe_seen |= dev_oe;
                b = (b << dw) | ((dw == 1) ? {7'h00, s[1]} : {4'h0, s} & 8'((1 << dw) - 1));
            end
            got.push_back(b);
        end
        repeat (4) @(negedge clk);
        spi_cs_n = 1'b1;
        h_oe = 4'h0;
        repeat (6) @(negedge clk);
    endtask : run
endmodule : mff_host_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mff_pkg::*;
    logic clk, reset, qe, cs_n, sclk, wdis, m_wdis;
    // idle lanes start low and toggle from one process only
    logic flt = 1'b0;
    logic [3:0] h_out, h_oe, lane, d_out, d_oe;
    logic [7:0] cmb, md;
    logic [1:0] wlen, m_wlen;
    logic [23:0] mem_addr;
    logic [7:0] mem_data;
    logic [7:0] ops[3] = '{OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT};
    logic [3:0] oes[3] = '{4'h2, 4'h3, 4'hF};
    int dws[3] = '{1, 2, 4};
    int bad_count, check_count, cycles, r;

    // array content is a pure function of the address
    function automatic logic [7:0] memv(logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h3C;
    endfunction : memv
    assign mem_data = memv(mem_addr);
    // undriven lanes toggle so a stale value can never pass
    for (genvar i = 0; i < 4; i++)
        assign lane[i] = d_oe[i] ? d_out[i] : (h_oe[i] ? h_out[i] : flt);

    mff_read_front uut (.clk(clk), .reset(reset), .spi_cs_n(cs_n),
        .spi_sclk(sclk), .data_lane_zero_in(lane[0]),
        .data_lane_zero_out(d_out[0]), .data_lane_zero_oe(d_oe[0]),
        .data_lane_one_in(lane[1]), .data_lane_one_out(d_out[1]),
        .data_lane_one_oe(d_oe[1]), .data_lane_two_in(lane[2]),
        .data_lane_two_out(d_out[2]), .data_lane_two_oe(d_oe[2]),
        .data_lane_three_in(lane[3]), .data_lane_three_out(d_out[3]),
        .data_lane_three_oe(d_oe[3]), .quad_enable_bit(qe),
        .continuous_mode_bits(cmb), .wrap_disable_bit(wdis),
        .wrap_length_field(wlen), .mem_addr(mem_addr), .mem_data(mem_data));
    mff_host_model host (.clk(clk), .spi_cs_n(cs_n), .spi_sclk(sclk),
        .h_out(h_out), .h_oe(h_oe), .lane(lane), .dev_oe(d_oe));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk)
        flt <= ~flt;

    task chk(input string name, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s: expected %h seen %h", name, e, g);
        end
    endtask : chk

    task results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    // model address step; wrap stays inside the aligned section
    function automatic logic [23:0] nxt(logic [23:0] x, logic wr);
        logic [23:0] msk;
        msk = 24'((8 << m_wlen) - 1);
        if (wr && !m_wdis)
            return (x & ~msk) | ((x + 24'h000001) & msk);
        return x + 24'h000001;
    endfunction : nxt

    task rd(input logic skip, input logic [7:0] op, input int aw,
            input logic [23:0] ad, input int mw, input logic [7:0] m,
            input int dm, input int dw, input int n, input logic wr,
            input logic [3:0] eoe);
        logic [23:0] x;
        x = ad;
        host.run(skip, op, aw, ad, mw, m, dm, dw, n);
        chk("oe in dummy", 24'h0, 24'(host.oe_bad));
        chk("oe pattern", 24'(eoe), 24'(host.oe_seen));
        if (eoe !== 4'h0)
        begin
            for (int i = 0; i < n; i++)
            begin
                chk("read byte", 24'(memv(x)), 24'(host.got[i]));
                x = nxt(x, wr);
            end
        end
    endtask : rd

    // one set-wrap frame: 24 dummy bits then the wrap byte on four lanes
    task wset(input logic [7:0] w);
        host.run(1'b0, OP_WRAP_SET, 4, 24'h000000, 4, w, 0, 1, 0);
        m_wdis = w[4];
        m_wlen = w[6:5];
        chk("wrap disable", 24'(m_wdis), 24'(wdis));
        chk("wrap length", 24'(m_wlen), 24'(wlen));
    endtask : wset

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            bad_count++;
            results();
        end
    end

    initial
    begin
        reset = 1'b1;
        qe = 1'b1;
        m_wdis = 1'b1;
        m_wlen = 2'h0;
        r = $urandom(95);
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        chk("mode bits", 24'h0, 24'(cmb));
        chk("wrap disable", 24'h1, 24'(wdis));
        chk("wrap length", 24'h0, 24'(wlen));
        $display("test reset values done");
        for (int k = 0; k < 3; k++)
            rd(0, ops[k], 1, 24'($urandom), 0, 0, 8, dws[k], 3, 0, oes[k]);
        $display("test output reads done");
        qe = 1'b0;
        rd(0, OP_QUAD_OUT, 1, 24'($urandom), 0, 0, 8, 4, 2, 0, 4'h0);
        rd(0, OP_QUAD_IO, 4, 24'($urandom), 4, 8'h20, 4, 4, 2, 0, 4'h0);
        chk("mode bits", 24'h0, 24'(cmb));
        qe = 1'b1;
        $display("test quad enable gate done");
        md = {4'h2, 4'($urandom)};
        rd(0, OP_DUAL_IO, 2, 24'($urandom), 2, md, 0, 2, 2, 0, 4'h3);
        chk("mode bits", 24'(md), 24'(cmb));
        rd(1, OP_DUAL_IO, 2, 24'($urandom), 2, 8'h0F, 0, 2, 2, 0, 4'h3);
        rd(0, OP_FAST, 1, 24'($urandom), 0, 0, 8, 1, 2, 0, 4'h2);
        $display("test dual continuous done");
        // quad frames leave by the one-byte exit, dual by the two-byte one:
        // a 16-clock exit in quad continuous mode would meet driven data
        for (int k = 0; k < 2; k++)
        begin
            rd(0, k ? OP_DUAL_IO : OP_QUAD_IO, 4 >> k, 24'($urandom),
               4 >> k, 8'h2A, k ? 0 : 4, 4 >> k, 2, 0,
               k ? 4'h3 : 4'hF);
            rd(1, k ? OP_DUAL_IO : OP_QUAD_IO, 4 >> k, 24'($urandom),
               4 >> k, 8'h25, k ? 0 : 4, 4 >> k, 2, 0,
               k ? 4'h3 : 4'hF);
            host.run(0, OP_MODE_RESET, 0, 0, k, 8'hFF, 0, 1, 0);
            chk("mode bits", 24'h0, 24'(cmb));
            rd(0, OP_FAST, 1, 24'($urandom), 0, 0, 8, 1, 1, 0, 4'h2);
        end
        $display("test quad continuous done");
        for (int k = 0; k < 4; k++)
        begin
            wset({1'b0, 2'(k), 1'b0, 4'h0});
            rd(0, OP_QUAD_IO, 4, 24'($urandom), 4, 8'h00, 4, 4, (8 << k) + 2, 1, 4'hF);
        end
        wset(8'h10);
        rd(0, OP_QUAD_IO, 4, {16'($urandom), 8'hFE}, 4, 8'h00, 4, 4, 4, 1, 4'hF);
        $display("test wrap done");
        results();
    end
endmodule : tb_top
`default_nettype wire
